// file: design/cbs_cond.sv
// Condition evaluator: classifies an operation and says whether its
// skip or branch is taken.
// Assumes operands are stable in the cycle they are evaluated.
`timescale 1ns/1ps
module cbs_cond (
    input  cbs_pkg::cbs_op_t op,
    input  wire logic [7:0]  flags,
    input  wire logic [7:0]  reg_val,
    input  wire logic [7:0]  io_val,
    input  wire logic [2:0]  bit_sel,
    output logic             is_cmp,
    output logic             is_skip,
    output logic             taken
);

    logic reg_bit;
    logic io_bit;
    logic sel_flag;

    assign reg_bit  = reg_val[bit_sel];
    assign io_bit   = io_val[bit_sel];
    assign sel_flag = flags[bit_sel];

    always_comb begin
        is_cmp  = 1'b0;
        is_skip = 1'b0;
        taken   = 1'b0;
        case (op)
            cbs_pkg::OP_COMPARE_IMMEDIATE: begin
                is_cmp = 1'b1;
            end
            cbs_pkg::OP_SKIP_REG_BIT_CLEAR: begin
                is_skip = 1'b1;
                taken   = ~reg_bit;
            end
            cbs_pkg::OP_SKIP_REG_BIT_SET: begin
                is_skip = 1'b1;
                taken   = reg_bit;
            end
            cbs_pkg::OP_SKIP_IO_BIT_CLEAR: begin
                is_skip = 1'b1;
                taken   = ~io_bit;
            end
            cbs_pkg::OP_SKIP_IO_BIT_SET: begin
                is_skip = 1'b1;
                taken   = io_bit;
            end
            cbs_pkg::OP_BRANCH_FLAG_SET:         taken = sel_flag;
            cbs_pkg::OP_BRANCH_FLAG_CLEAR:       taken = ~sel_flag;
            cbs_pkg::OP_BRANCH_EQUAL:            taken = flags[cbs_pkg::FLAG_Z];
            cbs_pkg::OP_BRANCH_NOT_EQUAL:        taken = ~flags[cbs_pkg::FLAG_Z];
            cbs_pkg::OP_BRANCH_CARRY_SET,
            cbs_pkg::OP_BRANCH_LOWER:            taken = flags[cbs_pkg::FLAG_C];
            cbs_pkg::OP_BRANCH_CARRY_CLEAR,
            cbs_pkg::OP_BRANCH_SAME_OR_HIGHER:   taken = ~flags[cbs_pkg::FLAG_C];
            cbs_pkg::OP_BRANCH_MINUS:            taken = flags[cbs_pkg::FLAG_N];
            cbs_pkg::OP_BRANCH_PLUS:             taken = ~flags[cbs_pkg::FLAG_N];
            // Computed from N and V directly, so a stale S bit cannot mislead
            cbs_pkg::OP_BRANCH_SIGNED_GE:
                taken = ~(flags[cbs_pkg::FLAG_N] ^ flags[cbs_pkg::FLAG_V]);
            cbs_pkg::OP_BRANCH_SIGNED_LT:
                taken = flags[cbs_pkg::FLAG_N] ^ flags[cbs_pkg::FLAG_V];
            cbs_pkg::OP_BRANCH_HALF_CARRY_SET:   taken = flags[cbs_pkg::FLAG_H];
            cbs_pkg::OP_BRANCH_HALF_CARRY_CLEAR: taken = ~flags[cbs_pkg::FLAG_H];
            cbs_pkg::OP_BRANCH_TRANSFER_SET:     taken = flags[cbs_pkg::FLAG_T];
            cbs_pkg::OP_BRANCH_TRANSFER_CLEAR:   taken = ~flags[cbs_pkg::FLAG_T];
            cbs_pkg::OP_BRANCH_OVERFLOW_SET:     taken = flags[cbs_pkg::FLAG_V];
            cbs_pkg::OP_BRANCH_OVERFLOW_CLEAR:   taken = ~flags[cbs_pkg::FLAG_V];
            cbs_pkg::OP_BRANCH_IRQ_DISABLED:     taken = ~flags[cbs_pkg::FLAG_I];
            default: begin
                taken = 1'b0;
            end
        endcase
    end

endmodule

// file: design/cbs_pkg.sv
// Package for the conditional branch and skip unit: status flag layout,
// operation codes, request carrier, step sizes and cycle counts.
// Assumes a single core clock; all users refer to names as cbs_pkg::name.
package cbs_pkg;

    // ==========================================================
    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ==========================================================
    // Values after reset
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;

    // ==========================================================
    // Program counter steps
    localparam logic [1:0] STEP_NEXT     = 2'h1;
    localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
    localparam logic [1:0] STEP_SKIP_TWO = 2'h3;
    localparam logic [1:0] BRANCH_BIAS   = 2'h1;

    // ==========================================================
    // Cycle counts per outcome
    localparam logic [1:0] CYC_PLAIN    = 2'h1;
    localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;

    // ==========================================================
    // Operation codes
    typedef enum logic [4:0] {
        OP_COMPARE_IMMEDIATE       = 5'h00,
        OP_SKIP_REG_BIT_CLEAR      = 5'h01,
        OP_SKIP_REG_BIT_SET        = 5'h02,
        OP_SKIP_IO_BIT_CLEAR       = 5'h03,
        OP_SKIP_IO_BIT_SET         = 5'h04,
        OP_BRANCH_FLAG_SET         = 5'h05,
        OP_BRANCH_FLAG_CLEAR       = 5'h06,
        OP_BRANCH_EQUAL            = 5'h07,
        OP_BRANCH_NOT_EQUAL        = 5'h08,
        OP_BRANCH_CARRY_SET        = 5'h09,
        OP_BRANCH_CARRY_CLEAR      = 5'h0A,
        OP_BRANCH_SAME_OR_HIGHER   = 5'h0B,
        OP_BRANCH_LOWER            = 5'h0C,
        OP_BRANCH_MINUS            = 5'h0D,
        OP_BRANCH_PLUS             = 5'h0E,
        OP_BRANCH_SIGNED_GE        = 5'h0F,
        OP_BRANCH_SIGNED_LT        = 5'h10,
        OP_BRANCH_HALF_CARRY_SET   = 5'h11,
        OP_BRANCH_HALF_CARRY_CLEAR = 5'h12,
        OP_BRANCH_TRANSFER_SET     = 5'h13,
        OP_BRANCH_TRANSFER_CLEAR   = 5'h14,
        OP_BRANCH_OVERFLOW_SET     = 5'h15,
        OP_BRANCH_OVERFLOW_CLEAR   = 5'h16,
        OP_BRANCH_IRQ_DISABLED     = 5'h17
    } cbs_op_t;

    // ==========================================================
    // Request carrier from the core's decode stage
    typedef struct packed {
        cbs_op_t    op;
        logic [7:0] reg_val;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [7:0] io_val;
        logic [6:0] k;
        logic       next_two_word;
    } cbs_req_t;

endpackage

// file: design/cbs_unit.sv
// Conditional branch and skip unit: compare-with-immediate, bit-test skips
// and relative conditional branches; owns the program counter and flags.
// Assumes the core drives req/start on sys_clk and holds nothing else
// of the flags; other ALU results arrive through the flag load port.
`timescale 1ns/1ps
module cbs_unit #(
    parameter int PCW = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  cbs_pkg::cbs_req_t      req,
    input  wire logic              flags_wr,
    input  wire logic [7:0]        flags_in,
    output logic [PCW-1:0]         pc,
    output logic [7:0]             status_flags,
    output logic                   busy,
    output logic                   done
);

    // ==========================================================
    // State and registers
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_STALL = 2'b10
    } cbs_state_t;

    cbs_state_t     state_q, state_d;
    logic [1:0]     stall_q, stall_d;
    logic [PCW-1:0] pc_q, pc_d;
    logic [7:0]     flags_q, flags_d;
    logic           done_q, done_d;

    logic           accept;
    logic           is_cmp;
    logic           is_skip;
    logic           taken;
    logic [1:0]     cycles;
    logic [8:0]     diff9;
    logic [7:0]     res;
    logic [7:0]     rd;
    logic [7:0]     kk;
    logic [PCW-1:0] offset;

    assign accept = start && (state_q == ST_IDLE);
    assign rd     = req.reg_val;
    assign kk     = req.imm;
    assign diff9  = {1'b0, rd} - {1'b0, kk};
    assign res    = diff9[7:0];
    assign offset = PCW'($signed(req.k));

    cbs_cond u_cond (
        .op      (req.op),
        .flags   (flags_q),
        .reg_val (req.reg_val),
        .io_val  (req.io_val),
        .bit_sel (req.bit_sel),
        .is_cmp  (is_cmp),
        .is_skip (is_skip),
        .taken   (taken)
    );

    // ==========================================================
    // Cycle count per outcome
    always_comb begin
        if (!taken || is_cmp) begin
            cycles = cbs_pkg::CYC_PLAIN;
        end else if (!is_skip) begin
            cycles = cbs_pkg::CYC_BR_TAKEN;
        end else if (req.next_two_word) begin
            cycles = cbs_pkg::CYC_SKIP_TWO;
        end else begin
            cycles = cbs_pkg::CYC_SKIP_ONE;
        end
    end

    // ==========================================================
    // Next state, PC and flags
    always_comb begin
        state_d = state_q;
        stall_d = stall_q;
        pc_d    = pc_q;
        flags_d = flags_q;
        done_d  = 1'b0;
        // A compare in the same cycle overrides Z, N, C, V and H of a core flag write; S, T and I come from the write
        if (flags_wr) begin
            flags_d = flags_in;
        end
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    if (is_cmp || !taken) begin
                        pc_d = pc_q + PCW'(cbs_pkg::STEP_NEXT);
                    end else if (!is_skip) begin
                        pc_d = pc_q + offset + PCW'(cbs_pkg::BRANCH_BIAS);
                    end else if (req.next_two_word) begin
                        pc_d = pc_q + PCW'(cbs_pkg::STEP_SKIP_TWO);
                    end else begin
                        pc_d = pc_q + PCW'(cbs_pkg::STEP_SKIP_ONE);
                    end
                    if (is_cmp) begin
                        flags_d[cbs_pkg::FLAG_Z] = (res == 8'h00);
                        flags_d[cbs_pkg::FLAG_N] = res[7];
                        flags_d[cbs_pkg::FLAG_C] = diff9[8];
                        flags_d[cbs_pkg::FLAG_V] = (rd[7] & ~kk[7] & ~res[7])
                                                 | (~rd[7] & kk[7] & res[7]);
                        flags_d[cbs_pkg::FLAG_H] = (~rd[3] & kk[3]) | (kk[3] & res[3])
                                                 | (res[3] & ~rd[3]);
                    end
                    if (cycles == cbs_pkg::CYC_PLAIN) begin
                        done_d = 1'b1;
                    end else begin
                        state_d = ST_STALL;
                        stall_d = cycles - 2'h1;
                    end
                end
            end
            ST_STALL: begin
                stall_d = stall_q - 2'h1;
                if (stall_q == 2'h1) begin
                    state_d = ST_IDLE;
                    done_d  = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                stall_d = 2'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            stall_q <= 2'h0;
            pc_q    <= PCW'(cbs_pkg::PC_RESET);
            flags_q <= cbs_pkg::FLAGS_RESET;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            stall_q <= stall_d;
            pc_q    <= pc_d;
            flags_q <= flags_d;
            done_q  <= done_d;
        end
    end

    assign pc           = pc_q;
    assign status_flags = flags_q;
    assign busy         = state_q[1];
    assign done         = done_q;

    // ==========================================================
    // Assertions
    property p_cmp_flags;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_COMPARE_IMMEDIATE |=>
            flags_q[cbs_pkg::FLAG_Z] == ($past(rd) == $past(kk))
            && flags_q[cbs_pkg::FLAG_C] == ($past(kk) > $past(rd)) && done_q;
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong");

    property p_skip_reg_clr;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_SKIP_REG_BIT_CLEAR && !req.reg_val[req.bit_sel]
            && !req.next_two_word |=> pc_q == $past(pc_q) + PCW'(2) ##1 done_q;
    endproperty
    a_skip_reg_clr: assert property (p_skip_reg_clr) else $error("reg clear skip wrong");

    property p_skip_reg_set;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_SKIP_REG_BIT_SET && req.reg_val[req.bit_sel]
            && req.next_two_word |=> pc_q == $past(pc_q) + PCW'(3) ##2 done_q;
    endproperty
    a_skip_reg_set: assert property (p_skip_reg_set) else $error("reg set skip wrong");

    property p_skip_io_clr;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_SKIP_IO_BIT_CLEAR && req.io_val[req.bit_sel]
            |=> pc_q == $past(pc_q) + PCW'(1) && done_q;
    endproperty
    a_skip_io_clr: assert property (p_skip_io_clr) else $error("io clear no-skip wrong");

    property p_skip_io_set;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_SKIP_IO_BIT_SET && req.io_val[req.bit_sel]
            && !req.next_two_word |=> busy ##1 done_q && !busy;
    endproperty
    a_skip_io_set: assert property (p_skip_io_set) else $error("io set skip timing wrong");

    property p_branch_taken;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && taken && !is_skip && !is_cmp
            |=> pc_q == $past(pc_q) + PCW'($signed($past(req.k))) + PCW'(1)
                && !done_q ##1 done_q;
    endproperty
    a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong");

    property p_branch_equal;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_BRANCH_EQUAL && !flags_q[cbs_pkg::FLAG_Z]
            |=> pc_q == $past(pc_q) + PCW'(1) && done_q;
    endproperty
    a_branch_equal: assert property (p_branch_equal) else $error("equal branch wrong");

    property p_signed_lt;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_BRANCH_SIGNED_LT
            && (flags_q[cbs_pkg::FLAG_N] != flags_q[cbs_pkg::FLAG_V]) |=> busy;
    endproperty
    a_signed_lt: assert property (p_signed_lt) else $error("signed lt not taken");

    property p_flags_kept;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && !is_cmp && !flags_wr |=> $stable(flags_q);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    property p_irq_disabled;
        @(posedge sys_clk) disable iff (sys_rst)
        accept && req.op == cbs_pkg::OP_BRANCH_IRQ_DISABLED && flags_q[cbs_pkg::FLAG_I]
            |=> done_q && !busy;
    endproperty
    a_irq_disabled: assert property (p_irq_disabled) else $error("irq branch wrong");

endmodule

// file: verif/tb.sv
// Self-checking bench for the conditional branch and skip unit.
// Assumes cbs_pkg is compiled first; drives all inputs on the falling edge.
`timescale 1ns/1ps
module tb;
    logic              sys_clk;
    logic              sys_rst;
    logic              start;
    cbs_pkg::cbs_req_t req;
    logic              flags_wr;
    logic [7:0]        flags_in;
    logic [15:0]       pc;
    logic [7:0]        status_flags;
    logic              busy;
    logic              done;
    int                num_errors;
    int                checks;
    logic [15:0]       exp_pc;

    cbs_unit #(.PCW(16)) dut_u (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .start        (start),
        .req          (req),
        .flags_wr     (flags_wr),
        .flags_in     (flags_in),
        .pc           (pc),
        .status_flags (status_flags),
        .busy         (busy),
        .done         (done)
    );

    always #12.5 sys_clk = ~sys_clk;

    // ==========================================================
    // Shared helpers
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic cbs_pkg::cbs_req_t mk(cbs_pkg::cbs_op_t op, logic [7:0] r,
        logic [7:0] imm, logic [2:0] bs, logic [7:0] io, logic [6:0] k, logic tw);
        return '{op, r, imm, bs, io, k, tw};
    endfunction

    // Expected compare flags; S, T and I keep their old value
    function automatic logic [7:0] cmp_flags(logic [7:0] a, logic [7:0] b, logic [7:0] old);
        logic [7:0] d;
        logic [7:0] f;
        d = a - b;
        f = old;
        f[cbs_pkg::FLAG_C] = a < b;
        f[cbs_pkg::FLAG_Z] = d == 8'h00;
        f[cbs_pkg::FLAG_N] = d[7];
        f[cbs_pkg::FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        f[cbs_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
        return f;
    endfunction

    function automatic logic br_taken(cbs_pkg::cbs_op_t op, logic [7:0] f, logic [2:0] s);
        case (op)
            cbs_pkg::OP_BRANCH_FLAG_SET:         return f[s];
            cbs_pkg::OP_BRANCH_FLAG_CLEAR:       return ~f[s];
            cbs_pkg::OP_BRANCH_EQUAL:            return f[1];
            cbs_pkg::OP_BRANCH_NOT_EQUAL:        return ~f[1];
            cbs_pkg::OP_BRANCH_CARRY_SET:        return f[0];
            cbs_pkg::OP_BRANCH_LOWER:            return f[0];
            cbs_pkg::OP_BRANCH_CARRY_CLEAR:      return ~f[0];
            cbs_pkg::OP_BRANCH_SAME_OR_HIGHER:   return ~f[0];
            cbs_pkg::OP_BRANCH_MINUS:            return f[2];
            cbs_pkg::OP_BRANCH_PLUS:             return ~f[2];
            cbs_pkg::OP_BRANCH_SIGNED_GE:        return ~(f[2] ^ f[3]);
            cbs_pkg::OP_BRANCH_SIGNED_LT:        return f[2] ^ f[3];
            cbs_pkg::OP_BRANCH_HALF_CARRY_SET:   return f[5];
            cbs_pkg::OP_BRANCH_HALF_CARRY_CLEAR: return ~f[5];
            cbs_pkg::OP_BRANCH_TRANSFER_SET:     return f[6];
            cbs_pkg::OP_BRANCH_TRANSFER_CLEAR:   return ~f[6];
            cbs_pkg::OP_BRANCH_OVERFLOW_SET:     return f[3];
            cbs_pkg::OP_BRANCH_OVERFLOW_CLEAR:   return ~f[3];
            default:                             return ~f[7];
        endcase
    endfunction

    task automatic set_flags(input logic [7:0] v);
        @(negedge sys_clk);
        flags_wr = 1'b1;
        flags_in = v;
        @(negedge sys_clk);
        flags_wr = 1'b0;
        chk({8'h00, status_flags}, {8'h00, v});
    endtask

    // Issues one request, waits a bounded time for done, checks busy on the way
    task automatic run_op(input cbs_pkg::cbs_req_t r, input logic [15:0] npc,
                          input logic [7:0] fl, input int cyc);
        int n;
        @(negedge sys_clk);
        req   = r;
        start = 1'b1;
        @(negedge sys_clk);
        start    = 1'b0;
        flags_wr = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 6) begin
            chk({15'h0000, busy}, 16'h0001);
            @(negedge sys_clk);
            n++;
        end
        if (done !== 1'b1) begin
            num_errors++;
            results();
        end
        chk(16'(n), 16'(cyc));
        chk({15'h0000, busy}, 16'h0000);
        chk(pc, npc);
        chk({8'h00, status_flags}, {8'h00, fl});
        exp_pc = npc;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_compare();
        logic [7:0] a [7] = '{8'h00, 8'h05, 8'h80, 8'h7F, 8'h10, 8'hFF, 8'h3C};
        logic [7:0] b [7] = '{8'h00, 8'h07, 8'h01, 8'hFF, 8'h01, 8'hFF, 8'h2D};
        logic [7:0] e;
        logic [7:0] f0;
        for (int i = 0; i < 7; i++) begin
            // Old flags come from the value loaded, not from the unit's output
            f0 = 8'hD0 ^ {a[i][3:0], b[i][3:0]};
            set_flags(f0);
            e = cmp_flags(a[i], b[i], f0);
            run_op(mk(cbs_pkg::OP_COMPARE_IMMEDIATE, a[i], b[i], 3'h0, 8'h00, 7'h00, 1'b0),
                   exp_pc + 16'h0001, e, 1);
        end
        // Load and compare on the same edge: compare fields override the load
        flags_wr = 1'b1;
        flags_in = 8'hFF;
        e = cmp_flags(8'h44, 8'h44, 8'hFF);
        run_op(mk(cbs_pkg::OP_COMPARE_IMMEDIATE, 8'h44, 8'h44, 3'h0, 8'h00, 7'h00, 1'b0),
               exp_pc + 16'h0001, e, 1);
        $display("test compare done");
    endtask

    task automatic t_skip();
        cbs_pkg::cbs_op_t op;
        logic [7:0]       v;
        logic             hit;
        set_flags(8'hA5);
        for (int i = 0; i < 16; i++) begin
            op  = cbs_pkg::cbs_op_t'(5'(1 + i / 4));
            v   = i[1] ? (8'h01 << i[2:0]) : ~(8'h01 << i[2:0]);
            hit = (op == cbs_pkg::OP_SKIP_REG_BIT_SET || op == cbs_pkg::OP_SKIP_IO_BIT_SET)
                  == i[1];
            if (op <= cbs_pkg::OP_SKIP_REG_BIT_SET) begin
                run_op(mk(op, v, 8'h00, i[2:0], ~v, 7'h00, i[0]),
                       exp_pc + (hit ? 16'(2 + i[0]) : 16'h0001), 8'hA5,
                       hit ? 2 + i[0] : 1);
            end else begin
                run_op(mk(op, ~v, 8'h00, i[2:0], v, 7'h00, i[0]),
                       exp_pc + (hit ? 16'(2 + i[0]) : 16'h0001), 8'hA5,
                       hit ? 2 + i[0] : 1);
            end
        end
        $display("test skip done");
    endtask

    task automatic t_branch();
        logic [7:0]       pat [6] = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h21, 8'hC2};
        logic [6:0]       ks  [4] = '{7'h05, 7'h7B, 7'h3F, 7'h40};
        cbs_pkg::cbs_op_t op;
        logic [6:0]       k;
        logic             tk;
        for (int p = 0; p < 6; p++) begin
            set_flags(pat[p]);
            for (int o = 5; o < 24; o++) begin
                for (int s = 0; s < 8; s++) begin
                    op = cbs_pkg::cbs_op_t'(5'(o));
                    k  = ks[(s + p + o) % 4];
                    tk = br_taken(op, pat[p], 3'(s));
                    run_op(mk(op, 8'h00, 8'h00, 3'(s), 8'h00, k, 1'b1),
                           exp_pc + (tk ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001),
                           pat[p], tk ? 2 : 1);
                end
            end
        end
        $display("test branch done");
    endtask

    task automatic t_refuse();
        logic [15:0] tgt;
        set_flags(8'h02);
        tgt = exp_pc + 16'h0005;
        @(negedge sys_clk);
        req   = mk(cbs_pkg::OP_BRANCH_EQUAL, 8'h00, 8'h00, 3'h0, 8'h00, 7'h04, 1'b0);
        start = 1'b1;
        @(negedge sys_clk);
        req = mk(cbs_pkg::OP_COMPARE_IMMEDIATE, 8'h00, 8'h01, 3'h0, 8'h00, 7'h00, 1'b0);
        chk({15'h0000, busy}, 16'h0001);
        @(negedge sys_clk);
        start = 1'b0;
        chk({15'h0000, done}, 16'h0001);
        chk(pc, tgt);
        @(negedge sys_clk);
        chk({15'h0000, done}, 16'h0000);
        chk({8'h00, status_flags}, 16'h0002);
        exp_pc = tgt;
        run_op(mk(cbs_pkg::cbs_op_t'(5'h1F), 8'h00, 8'h00, 3'h0, 8'h00, 7'h10, 1'b0),
               exp_pc + 16'h0001, 8'h02, 1);
        $display("test refuse done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        sys_clk    = 1'b0;
        sys_rst    = 1'b1;
        start      = 1'b0;
        req        = mk(cbs_pkg::OP_BRANCH_EQUAL, 8'h00, 8'h00, 3'h0, 8'h00, 7'h00, 1'b0);
        flags_wr   = 1'b0;
        flags_in   = 8'h00;
        num_errors = 0;
        checks     = 0;
        exp_pc     = cbs_pkg::PC_RESET;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(pc, cbs_pkg::PC_RESET);
        chk({8'h00, status_flags}, {8'h00, cbs_pkg::FLAGS_RESET});
        chk({14'h0000, busy, done}, 16'h0000);
        sys_rst = 1'b0;
        $display("test reset done");
        t_compare();
        t_skip();
        t_branch();
        t_refuse();
        results();
    end
endmodule
